// [hw/dbu_pkg.sv]
package dbu_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_IMASK = 8'h08;
  localparam logic [7:0] OFF_EVENT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RHR = 8'h18;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam logic [7:0] OFF_CHIP_ID = 8'h40;
  localparam logic [7:0] OFF_EXT_ID = 8'h44;
  localparam logic [7:0] OFF_FNR = 8'h48;

  // port_control_register command bits
  localparam int CTRL_RX_RESET = 2;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_RX_DIS = 5;
  localparam int CTRL_RST_STA = 8;

  // mode register field
  localparam int MODE_PARITY_EN = 9;

  // port_status_register bits
  localparam int ST_RX_READY = 0;
  localparam int ST_RX_ON = 1;
  localparam int ST_OVERRUN = 5;
  localparam int ST_DCC_RX = 30;
  localparam int ST_DCC_TX = 31;

  // sticky event bits, shared by event and mask registers
  localparam int EV_W = 4;
  localparam int EV_CHAR = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_DCC_RX = 2;
  localparam int EV_DCC_TX = 3;

  // baud generation and sampling
  localparam int BAUD_W = 17;
  localparam int OVERSAMPLE = 16;
  localparam int START_LOWS = 7;
  localparam int FIRST_SAMPLE = 24;
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LOW_VALID = 3'(START_LOWS);
  localparam logic [4:0] FIRST_LOAD = 5'(FIRST_SAMPLE - START_LOWS - 1);
  localparam logic [4:0] BIT_LOAD = 5'(OVERSAMPLE - 1);
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

  // values after reset
  localparam logic [BAUD_W-1:0] BAUD_RST = 17'h00000;
  localparam logic [EV_W-1:0] IMASK_RST = 4'h0;
  localparam logic FNR_RST = 1'b0;
  localparam logic PARITY_RST = 1'b0;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_DATA = 2'b01,
    RX_PARITY = 2'b11,
    RX_STOP = 2'b10
  } dbu_rx_state_t;
endpackage

// [hw/dbu_baud.sv]
`timescale 1ns/1ps
module dbu_baud import dbu_pkg::*; #(
  parameter int DIV_W = BAUD_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // divisor in, oversampling tick out
  input wire logic [DIV_W-1:0] divisor,
  output logic sample_tick
);
  logic [DIV_W-1:0] cnt;

  // one tick per divisor clocks gives sixteen ticks per bit period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      sample_tick <= 1'b0;
    end else if (divisor == '0) begin
      cnt <= '0;
      sample_tick <= 1'b0;
    end else if (cnt >= divisor - 1'b1) begin
      // >= so a smaller divisor written mid-count cannot stall the count
      cnt <= '0;
      sample_tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      sample_tick <= 1'b0;
    end
  end

  baud_off_a: assert property (@(posedge clk) disable iff (!rstn)
    divisor == '0 |=> !sample_tick) else $error("tick while divisor is zero");

  tick_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
    (sample_tick && divisor == 3) ##1 (divisor == 3) [*2] |-> !sample_tick && !$past(sample_tick))
    else $error("tick spacing differs from divisor");
endmodule

// [hw/dbu_rx_top.sv]
// What this block does
// - The baud generator divides the master clock by sixteen times the divisor to form the bit period.
// - A divisor of zero stops the bit clock and holds the receiver in hunt; the enable state, registers and emulator channel stay live.
// - The divisor spans values up to 131071, giving rates from clock/(16*131071) to clock/16.
// - The port is asynchronous only, eight-bit characters with optional parity, and has no clock pin.
// - The receiver uses the one bit-rate generator and there is no transmitter; there is no receive timeout or guard time.
// - After reset the receiver is off; the enable command makes it hunt for a start bit.
// - The disable command stops an idle receiver at once, else the current character ends first.
// - The receiver reset command aborts at once, disables, and drops any character in progress.
// - A low on the receive pin is a start bit only if it lasts more than 7 sampling ticks.
// - The first data sample is 24 ticks after the falling edge, each later one 16 ticks on.
// - A finished character goes to the holding register and sets receive ready; reading it clears ready.
// - The emulator channel read-full and write-full signals are visible to software and can interrupt.
// - Software can force the emulator test-reset line to block in-circuit emulator access.
// - Read-only identifier registers report device, revision, memories and peripherals.
// - A character finishing while ready is still set and not being read that cycle raises overrun, held until reset status.
`timescale 1ns/1ps
module dbu_rx_top import dbu_pkg::*; #(
  parameter logic [DATA_W-1:0] CHIP_ID = 32'h1234_5678, // arbitrary value
  parameter logic [DATA_W-1:0] EXT_ID = 32'h0000_0000 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // serial pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  // emulator side
  input wire logic dcc_read_full,
  input wire logic dcc_write_full,
  output logic emulator_test_reset,
  // interrupt
  output logic irq
);
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    return strobe && (addr == off);
  endfunction

  logic [BAUD_W-1:0] baud_divisor;
  logic parity_en;
  logic [EV_W-1:0] imask;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] next_events;
  logic [EV_W-1:0] ev_set;
  logic [DATA_W-1:0] next_rdata;
  logic sample_tick;
  logic port_active;
  logic ctrl_wr;
  logic cmd_rst;
  logic cmd_en;
  logic cmd_dis;
  logic cmd_rst_sta;
  logic rhr_rd;
  logic rx_step;
  logic char_done;
  dbu_rx_state_t rx_state;
  logic rx_on;
  logic stop_pending;
  logic [2:0] low_cnt;
  logic [4:0] tick_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] receive_holding_register;
  logic receive_ready_flag;
  logic overrun_flag;
  logic dcc_rx_prev;
  logic dcc_tx_prev;

  // one shared sampling tick; a transmitter would hang off the same tick
  dbu_baud #(.DIV_W(BAUD_W)) u_baud (
    .clk(clk),
    .rstn(rstn),
    .divisor(baud_divisor),
    .sample_tick(sample_tick)
  );

  assign port_active = (baud_divisor != '0);
  assign ctrl_wr = hit(reg_wr, reg_addr, OFF_CTRL);
  assign cmd_rst = ctrl_wr && reg_wdata[CTRL_RX_RESET];
  assign cmd_en = ctrl_wr && reg_wdata[CTRL_RX_EN];
  assign cmd_dis = ctrl_wr && reg_wdata[CTRL_RX_DIS];
  assign cmd_rst_sta = ctrl_wr && reg_wdata[CTRL_RST_STA];
  assign rhr_rd = hit(reg_rd, reg_addr, OFF_RHR);
  // an idle receiver that is being disabled must not take a start bit this cycle
  assign rx_step = sample_tick && rx_on && port_active && !cmd_rst && !(cmd_dis && rx_state == RX_HUNT);
  assign char_done = rx_step && (rx_state == RX_STOP) && (tick_cnt == '0);

  // configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      baud_divisor <= BAUD_RST;
      parity_en <= PARITY_RST;
      imask <= IMASK_RST;
      emulator_test_reset <= FNR_RST;
    end else begin
      if (hit(reg_wr, reg_addr, OFF_BAUD)) begin
        baud_divisor <= reg_wdata[BAUD_W-1:0];
      end
      if (hit(reg_wr, reg_addr, OFF_MODE)) begin
        parity_en <= reg_wdata[MODE_PARITY_EN];
      end
      if (hit(reg_wr, reg_addr, OFF_IMASK)) begin
        imask <= reg_wdata[EV_W-1:0];
      end
      if (hit(reg_wr, reg_addr, OFF_FNR)) begin
        emulator_test_reset <= reg_wdata[0];
      end
    end
  end

  // no transmitter here: the line idles high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_tx_pin <= 1'b1;
    end else begin
      serial_tx_pin <= 1'b1;
    end
  end

  // receiver enable state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_on <= 1'b0;
      stop_pending <= 1'b0;
    end else if (cmd_rst) begin
      rx_on <= 1'b0;
      stop_pending <= 1'b0;
    end else if (cmd_dis && rx_state == RX_HUNT) begin
      rx_on <= 1'b0;
      stop_pending <= 1'b0;
    end else if (cmd_dis) begin
      stop_pending <= 1'b1;
    end else if (char_done && stop_pending) begin
      rx_on <= 1'b0;
      stop_pending <= 1'b0;
    end else if (cmd_en) begin
      rx_on <= 1'b1;
      stop_pending <= 1'b0;
    end
  end

  // character framing, stepped once per sampling tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= RX_HUNT;
      low_cnt <= '0;
      tick_cnt <= '0;
      bit_cnt <= '0;
      shift <= '0;
    end else if (cmd_rst || !port_active || !rx_on) begin
      rx_state <= RX_HUNT;
      low_cnt <= '0;
      tick_cnt <= '0;
      bit_cnt <= '0;
    end else if (rx_step) begin
      unique case (rx_state)
        RX_HUNT: begin
          if (serial_rx_pin) begin
            low_cnt <= '0;
          end else if (low_cnt == LOW_VALID) begin
            // eighth low tick: the edge was seven ticks ago
            rx_state <= RX_DATA;
            low_cnt <= '0;
            tick_cnt <= FIRST_LOAD;
            bit_cnt <= '0;
          end else begin
            low_cnt <= low_cnt + 1'b1;
          end
        end
        RX_DATA: begin
          if (tick_cnt == '0) begin
            shift <= {serial_rx_pin, shift[7:1]};
            tick_cnt <= BIT_LOAD;
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == LAST_BIT) begin
              rx_state <= parity_en ? RX_PARITY : RX_STOP;
            end
          end else begin
            tick_cnt <= tick_cnt - 1'b1;
          end
        end
        RX_PARITY: begin
          // parity bit time is waited out; the level is neither sampled nor judged here
          if (tick_cnt == '0) begin
            tick_cnt <= BIT_LOAD;
            rx_state <= RX_STOP;
          end else begin
            tick_cnt <= tick_cnt - 1'b1;
          end
        end
        RX_STOP: begin
          if (tick_cnt == '0) begin
            rx_state <= RX_HUNT;
          end else begin
            tick_cnt <= tick_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // holding register and status flags; a new character beats a same-cycle read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      receive_holding_register <= '0;
      receive_ready_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      if (char_done) begin
        receive_holding_register <= shift;
        receive_ready_flag <= 1'b1;
      end else if (rhr_rd) begin
        receive_ready_flag <= 1'b0;
      end
      if (char_done && receive_ready_flag && !rhr_rd) begin
        overrun_flag <= 1'b1;
      end else if (cmd_rst_sta) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    ev_set = '0;
    ev_set[EV_CHAR] = char_done;
    ev_set[EV_OVERRUN] = char_done && receive_ready_flag && !rhr_rd;
    ev_set[EV_DCC_RX] = dcc_read_full && !dcc_rx_prev;
    ev_set[EV_DCC_TX] = dcc_write_full && !dcc_tx_prev;
    next_events = events;
    if (hit(reg_wr, reg_addr, OFF_EVENT)) begin
      next_events = events & ~reg_wdata[EV_W-1:0];
    end
    next_events = next_events | ev_set;
  end

  // irq is one cycle behind the event bit; shared line, software must poll sources
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      events <= '0;
      dcc_rx_prev <= 1'b0;
      dcc_tx_prev <= 1'b0;
      irq <= 1'b0;
    end else begin
      events <= next_events;
      dcc_rx_prev <= dcc_read_full;
      dcc_tx_prev <= dcc_write_full;
      irq <= |(events & imask);
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_MODE: next_rdata[MODE_PARITY_EN] = parity_en;
        OFF_IMASK: next_rdata[EV_W-1:0] = imask;
        OFF_EVENT: next_rdata[EV_W-1:0] = events;
        OFF_STATUS: begin
          next_rdata[ST_RX_READY] = receive_ready_flag;
          next_rdata[ST_RX_ON] = rx_on;
          next_rdata[ST_OVERRUN] = overrun_flag;
          next_rdata[ST_DCC_RX] = dcc_read_full;
          next_rdata[ST_DCC_TX] = dcc_write_full;
        end
        OFF_RHR: next_rdata[7:0] = receive_holding_register;
        OFF_BAUD: next_rdata[BAUD_W-1:0] = baud_divisor;
        OFF_CHIP_ID: next_rdata = CHIP_ID;
        OFF_EXT_ID: next_rdata = EXT_ID;
        OFF_FNR: next_rdata[0] = emulator_test_reset;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  ready_set_a: assert property (@(posedge clk) disable iff (!rstn)
    char_done |=> receive_ready_flag && receive_holding_register == $past(shift))
    else $error("character did not reach holding register");

  ready_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    rhr_rd && !char_done |=> !receive_ready_flag)
    else $error("ready not cleared by holding read");

  overrun_set_a: assert property (@(posedge clk) disable iff (!rstn)
    char_done && receive_ready_flag && !rhr_rd |=> overrun_flag)
    else $error("overrun not flagged");

  overrun_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    overrun_flag && !cmd_rst_sta |=> overrun_flag)
    else $error("overrun dropped without reset status");

  rx_abort_a: assert property (@(posedge clk) disable iff (!rstn)
    cmd_rst |=> rx_state == RX_HUNT && !rx_on && !char_done)
    else $error("receiver reset did not abort");

  idle_disable_a: assert property (@(posedge clk) disable iff (!rstn)
    cmd_dis && !cmd_rst && rx_state == RX_HUNT |=> !rx_on && rx_state == RX_HUNT)
    else $error("idle receiver kept running after disable");

  busy_disable_a: assert property (@(posedge clk) disable iff (!rstn)
    cmd_dis && !cmd_rst && rx_state != RX_HUNT && rx_on && port_active |=> rx_on)
    else $error("busy receiver stopped before stop bit");

  off_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !rx_on |-> rx_state == RX_HUNT)
    else $error("disabled receiver left hunt state");

  start_qual_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_state == RX_HUNT ##1 rx_state == RX_DATA |-> $past(low_cnt) == 3'h7 && !$past(serial_rx_pin))
    else $error("start accepted without eight low ticks");

  first_sample_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_state == RX_HUNT ##1 rx_state == RX_DATA |-> tick_cnt == 5'h10 && bit_cnt == 3'h0)
    else $error("first sample not 24 ticks after edge");

  bit_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_step && rx_state == RX_DATA && tick_cnt == '0 |=> tick_cnt == 5'h0F)
    else $error("bit spacing is not 16 ticks");

  port_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !port_active |=> rx_state == RX_HUNT && !char_done)
    else $error("receiver active with zero divisor");

  emu_force_a: assert property (@(posedge clk) disable iff (!rstn)
    hit(reg_wr, reg_addr, OFF_FNR) |=> emulator_test_reset == $past(reg_wdata[0]))
    else $error("emulator reset force not taken");

  irq_level_a: assert property (@(posedge clk) disable iff (!rstn)
    ##1 irq == $past(|(events & imask)))
    else $error("interrupt does not follow masked events");
endmodule

// [test/dbu_console.sv]
`timescale 1ns/1ps
module dbu_console (
  // clock
  input wire logic clk,
  // serial line toward the port, idle high
  output logic line
);
  initial line = 1'b1;

  task automatic bit_out(input logic v, input int clks);
    line <= v;
    repeat (clks) @(posedge clk);
  endtask

  // callers enter just after a rising edge
  task automatic send_char(input logic [7:0] ch, input logic par_en, input int clks);
    bit_out(1'b0, clks);
    for (int i = 0; i < 8; i++) begin
      bit_out(ch[i], clks);
    end
    if (par_en) begin
      bit_out(^ch, clks);
    end
    bit_out(1'b1, clks);
  endtask

  // long high tail so a wrongly accepted start would have time to finish a character
  task automatic glitch(input int lows);
    bit_out(1'b0, lows);
    bit_out(1'b1, 200);
  endtask
endmodule

// [test/debug_uart_rx_baud_test.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module debug_uart_rx_baud_test import dbu_pkg::*; ;
  localparam logic [DATA_W-1:0] TB_CHIP = 32'h0BAD_F00D; // arbitrary value
  localparam logic [DATA_W-1:0] TB_EXT = 32'h0000_0000; // arbitrary value
  localparam logic [31:0] S_RDY = 32'h1 << ST_RX_READY;
  localparam logic [31:0] S_ON = 32'h1 << ST_RX_ON;
  localparam logic [31:0] S_OVR = 32'h1 << ST_OVERRUN;
  localparam logic [31:0] S_DCC = (32'h1 << ST_DCC_RX) | (32'h1 << ST_DCC_TX);
  localparam logic [31:0] C_EN = 32'h1 << CTRL_RX_EN;
  localparam logic [31:0] C_DIS = 32'h1 << CTRL_RX_DIS;
  localparam logic [31:0] C_RST = 32'h1 << CTRL_RX_RESET;
  localparam logic [31:0] C_STA = 32'h1 << CTRL_RST_STA;
  localparam int NREG = 10;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic dcc_read_full = 1'b0;
  logic dcc_write_full = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic serial_rx_pin;
  logic serial_tx_pin;
  logic emulator_test_reset;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 28;
  logic rd_pend = 1'b0;
  logic [31:0] want;
  logic [31:0] exp_q[$];
  logic [7:0] b;
  logic [7:0] reset_addr [NREG] = '{OFF_MODE, OFF_IMASK, OFF_EVENT, OFF_STATUS, OFF_RHR, OFF_BAUD,
    OFF_FNR, OFF_CHIP_ID, OFF_EXT_ID, 8'h10};
  logic [31:0] reset_val [NREG] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, TB_CHIP, TB_EXT, 32'h0};

  always #50 clk = ~clk;

  dbu_rx_top #(.CHIP_ID(TB_CHIP), .EXT_ID(TB_EXT)) dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .dcc_read_full(dcc_read_full), .dcc_write_full(dcc_write_full),
    .emulator_test_reset(emulator_test_reset), .irq(irq)
  );

  dbu_console console (
    .clk(clk),
    .line(serial_rx_pin)
  );

  // read data stands only in the cycle after the strobe, so look mid-cycle
  always @(negedge clk) begin
    if (rd_pend) begin
      want = exp_q.pop_front();
      `CHK(reg_rdata, want)
    end
    rd_pend = reg_rd;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // trailing idle edge keeps one strobe from being assigned twice in a time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk);
    `CHK(irq, e)
    @(posedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < NREG; i++) begin
      rd(reset_addr[i], reset_val[i]);
    end
    done("reset values");
    wr(OFF_BAUD, 32'h1);
    console.send_char(8'h5A, 1'b0, 16);
    rd(OFF_STATUS, 32'h0);
    done("receiver off");
    wr(OFF_CTRL, C_EN);
    console.glitch(7);
    rd(OFF_STATUS, S_ON);
    rd(OFF_EVENT, 32'h0);
    done("short low");
    wr(OFF_IMASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      console.send_char(b, 1'b0, 16);
      chk_irq(1'b1);
      rd(OFF_RHR, {24'h0, b});
      rd(OFF_STATUS, S_ON);
      wr(OFF_EVENT, 32'h1);
      chk_irq(1'b0);
    end
    done("random chars");
    console.send_char(8'h3C, 1'b0, 16);
    console.send_char(8'hC3, 1'b0, 16);
    rd(OFF_STATUS, S_ON | S_RDY | S_OVR);
    rd(OFF_RHR, 32'hC3);
    rd(OFF_EVENT, 32'h3);
    wr(OFF_CTRL, C_STA);
    rd(OFF_STATUS, S_ON);
    wr(OFF_EVENT, 32'h3);
    done("overrun");
    wr(OFF_CTRL, C_DIS);
    rd(OFF_STATUS, 32'h0);
    console.send_char(8'h81, 1'b0, 16);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CTRL, C_EN);
    fork
      console.send_char(8'hA5, 1'b0, 16);
      begin
        repeat (60) @(posedge clk);
        wr(OFF_CTRL, C_DIS);
      end
    join
    rd(OFF_STATUS, S_RDY);
    rd(OFF_RHR, 32'hA5);
    wr(OFF_EVENT, 32'hF);
    done("disable");
    wr(OFF_CTRL, C_EN);
    fork
      console.send_char(8'h66, 1'b0, 16);
      begin
        repeat (60) @(posedge clk);
        wr(OFF_CTRL, C_RST);
      end
    join
    rd(OFF_STATUS, 32'h0);
    rd(OFF_EVENT, 32'h0);
    done("receiver reset");
    b = 8'($random(seed));
    wr(OFF_BAUD, 32'h3);
    wr(OFF_MODE, 32'h1 << MODE_PARITY_EN);
    wr(OFF_CTRL, C_EN);
    console.send_char(b, 1'b1, 48);
    rd(OFF_RHR, {24'h0, b});
    rd(OFF_BAUD, 32'h3);
    wr(OFF_MODE, 32'h0);
    wr(OFF_EVENT, 32'hF);
    wr(OFF_BAUD, 32'h0001_0000);
    rd(OFF_BAUD, 32'h0001_0000);
    wr(OFF_BAUD, 32'h0);
    console.send_char(8'h42, 1'b0, 16);
    rd(OFF_STATUS, S_ON);
    rd(OFF_EVENT, 32'h0);
    done("divisor");
    dcc_read_full <= 1'b1;
    dcc_write_full <= 1'b1;
    repeat (2) @(posedge clk);
    rd(OFF_STATUS, S_ON | S_DCC);
    rd(OFF_EVENT, 32'hC);
    wr(OFF_IMASK, 32'h4);
    chk_irq(1'b1);
    rd(OFF_EVENT, 32'hC);
    wr(OFF_EVENT, 32'hC);
    chk_irq(1'b0);
    done("emulator channel");
    wr(OFF_FNR, 32'h1);
    rd(OFF_FNR, 32'h1);
    @(negedge clk);
    `CHK(emulator_test_reset, 1'b1)
    `CHK(serial_tx_pin, 1'b1)
    @(posedge clk);
    wr(OFF_CHIP_ID, 32'h0);
    rd(OFF_CHIP_ID, TB_CHIP);
    done("identity and test reset");
    print_verdict();
  end
endmodule
